/* File: verilog/iep_bank.sv */
// Interrupt flag, enable and priority register bank with APB slave
//
// Contract
// RL1 - Serial error flag is bit 1, flag register 4
// RL2 - Unimplemented bits read zero, ignore writes
// RL3 - Enable one passes request, zero blocks it
// RL4 - Enable register 0 source bit map
// RL5 - Enable register 1 source bit map
// RL6 - Enable register 4 holds only bit 1
// RL7 - Priority 7 highest, code zero disables source
// RL8 - Reset clears flags, enables; priorities load 100
// RL9 - Priority register 0 field layout
// RL10 - Priority register 1 layout, low nibble zero
// RL11 - Request needs flag, enable, nonzero priority; highest
// RL12 - CPU level is top bit over three bits
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
module iep_bank (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral flags held elsewhere: ext0,cap1,cmp1,tmr1,cap2,cmp2,tmr2
    input  wire logic [6:0]  periph_flags,
    input  wire logic        serial_error_req,
    // Processor level
    input  wire logic [2:0]  cpu_level_bits,
    input  wire logic        cpu_level_top_bit,
    // Request to processor
    output logic             req_valid,
    output logic [2:0]       req_src,
    output logic [2:0]       req_level,
    output logic             irq,
    // Enable bits for sources arbitrated elsewhere
    output logic [15:0]      enable_0_bits,
    output logic [15:0]      enable_1_bits
);

    // ========================================
    // Helpers
    // Keep only implemented bits of a write
    function automatic logic [15:0] wr_field(input logic [31:0] wd,
                                             input logic [15:0] mask);
        return wd[15:0] & mask;
    endfunction

    // Extract a 3-bit priority field
    function automatic logic [2:0] prio_of(input logic [15:0] r,
                                           input logic [3:0]  lsb);
        return r[lsb +: 3];
    endfunction

    // ========================================
    // State
    logic [15:0] flag4_q, flag4_d;        // Flag register 4
    logic [15:0] en0_q, en0_d;            // Enable register 0
    logic [15:0] en1_q, en1_d;            // Enable register 1
    logic [15:0] en4_q, en4_d;            // Enable register 4
    logic [15:0] prio0_q, prio0_d;        // Priority register 0
    logic [15:0] prio1_q, prio1_d;        // Priority register 1
    logic [1:0]  stat_q, stat_d;          // Sticky events
    logic [1:0]  mask_q, mask_d;          // Event mask
    logic        irq_q, irq_d;            // Interrupt output
    logic [31:0] prdata_q, prdata_d;      // Read data
    logic        pready_q, pready_d;      // Access phase answer
    logic        pslverr_q, pslverr_d;    // Unmapped address
    logic        req_valid_q, req_valid_d;
    logic [2:0]  req_src_q, req_src_d;
    logic [2:0]  req_level_q, req_level_d;

    // ========================================
    // Decode
    logic        setup;                   // Setup phase of a transfer
    logic        wr_en;                   // Write commits this edge
    logic        hit;                     // Mapped address
    logic [15:0] wdat;                    // Raw low write half
    logic [3:0]  cpu_level;               // Processor level, 0..15
    logic [7:0]  pend;                    // Pending, enabled, leveled
    logic [23:0] lvls;                    // Packed levels
    logic        pick_found;
    logic [2:0]  pick_idx;
    logic [2:0]  pick_level;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_q;
    assign wdat  = pwdata[15:0];
    assign hit   = (paddr == iep_pkg::OFF_FLAG4) || (paddr == iep_pkg::OFF_EN0) ||
                   (paddr == iep_pkg::OFF_EN1) || (paddr == iep_pkg::OFF_EN4) ||
                   (paddr == iep_pkg::OFF_PRIO0) || (paddr == iep_pkg::OFF_PRIO1) ||
                   (paddr == iep_pkg::OFF_IRQ_STAT) || (paddr == iep_pkg::OFF_IRQ_MASK) ||
                   (paddr == iep_pkg::OFF_REQ_STAT);
    // Above 7 means trap level: no 3-bit source can beat it
    assign cpu_level = {cpu_level_top_bit, cpu_level_bits};  // RL12

    // ========================================
    // Source levels and pending vector
    always_comb begin
        lvls = {iep_pkg::SERR_LEVEL,
                prio_of(prio1_q, iep_pkg::TMR_PRIO_LSB),
                prio_of(prio1_q, iep_pkg::CMP_PRIO_LSB),
                prio_of(prio1_q, iep_pkg::CAP_PRIO_LSB),
                prio_of(prio0_q, iep_pkg::TMR_PRIO_LSB),  // RL9
                prio_of(prio0_q, iep_pkg::CMP_PRIO_LSB),
                prio_of(prio0_q, iep_pkg::CAP_PRIO_LSB),
                prio_of(prio0_q, iep_pkg::EXT_PRIO_LSB)};
        // Flag and enable must both be set
        pend = {flag4_q[iep_pkg::SERR_BIT] & en4_q[iep_pkg::SERR_BIT],
                periph_flags[6] & en0_q[iep_pkg::TMR2_BIT],
                periph_flags[5] & en0_q[iep_pkg::CMP2_BIT],
                periph_flags[4] & en0_q[iep_pkg::CAP2_BIT],
                periph_flags[3] & en0_q[iep_pkg::TMR1_BIT],
                periph_flags[2] & en0_q[iep_pkg::CMP1_BIT],
                periph_flags[1] & en0_q[iep_pkg::CAP1_BIT],
                periph_flags[0] & en0_q[iep_pkg::EXT0_BIT]};  // RL3 RL4
        // Code zero removes the source entirely
        for (int i = 0; i < iep_pkg::NSRC; i++) begin
            if (lvls[3*i +: 3] == 3'h0) begin
                pend[i] = 1'b0;  // RL7
            end
        end
    end

    // Highest level wins, lowest index on ties
    iep_prio_pick u_pick (
        .pend  (pend),
        .lvls  (lvls),
        .found (pick_found),
        .idx   (pick_idx),
        .level (pick_level)
    );

    // ========================================
    // Register next values
    always_comb begin
        flag4_d = flag4_q;
        en0_d   = en0_q;
        en1_d   = en1_q;
        en4_d   = en4_q;
        prio0_d = prio0_q;
        prio1_d = prio1_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        if (wr_en) begin
            unique case (paddr)
                // Masks drop writes to unimplemented bits
                iep_pkg::OFF_FLAG4:    flag4_d = wr_field(pwdata, iep_pkg::FLAG4_MASK);  // RL1 RL2
                iep_pkg::OFF_EN0:      en0_d   = wr_field(pwdata, iep_pkg::EN0_MASK);    // RL4
                iep_pkg::OFF_EN1:      en1_d   = wr_field(pwdata, iep_pkg::EN1_MASK);    // RL5
                iep_pkg::OFF_EN4:      en4_d   = wr_field(pwdata, iep_pkg::EN4_MASK);    // RL6
                iep_pkg::OFF_PRIO0:    prio0_d = wr_field(pwdata, iep_pkg::PRIO0_MASK);  // RL9
                iep_pkg::OFF_PRIO1:    prio1_d = wr_field(pwdata, iep_pkg::PRIO1_MASK);  // RL10
                iep_pkg::OFF_IRQ_MASK: mask_d  = wdat[1:0] & iep_pkg::IRQ_MASK_W;
                // Write one to clear
                iep_pkg::OFF_IRQ_STAT: stat_d  = stat_q & ~wdat[1:0];
                default: ;
            endcase
        end
        // A request in the clearing cycle still lands
        if (serial_error_req) begin
            flag4_d[iep_pkg::SERR_BIT] = 1'b1;  // RL1
            stat_d[iep_pkg::IRQ_SERR]  = 1'b1;
        end
        if (req_valid_d && !req_valid_q) begin
            stat_d[iep_pkg::IRQ_REQ] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // ========================================
    // Request next values
    always_comb begin
        // Only strictly above the processor level is passed on
        req_valid_d = pick_found && ({1'b0, pick_level} > cpu_level);  // RL11 RL12
        req_src_d   = req_valid_d ? pick_idx : 3'h0;
        req_level_d = req_valid_d ? pick_level : 3'h0;
    end

    // ========================================
    // APB answer next values; read data captured in setup, so the
    // slave answers on the first access cycle with no wait
    always_comb begin
        pready_d  = setup;
        pslverr_d = setup && !hit;
        prdata_d  = 32'h0000_0000;
        if (setup) begin
            unique case (paddr)
                iep_pkg::OFF_FLAG4:    prdata_d[15:0] = flag4_q;
                iep_pkg::OFF_EN0:      prdata_d[15:0] = en0_q;
                iep_pkg::OFF_EN1:      prdata_d[15:0] = en1_q;
                iep_pkg::OFF_EN4:      prdata_d[15:0] = en4_q;
                iep_pkg::OFF_PRIO0:    prdata_d[15:0] = prio0_q;
                iep_pkg::OFF_PRIO1:    prdata_d[15:0] = prio1_q;
                iep_pkg::OFF_IRQ_STAT: prdata_d[1:0]  = stat_q;
                iep_pkg::OFF_IRQ_MASK: prdata_d[1:0]  = mask_q;
                iep_pkg::OFF_REQ_STAT: prdata_d[10:0] = {cpu_level, req_level_q, req_src_q, req_valid_q};
                default:               prdata_d       = 32'h0000_0000;
            endcase
        end
    end

    // ========================================
    // All flip-flops; clock enable low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag4_q     <= iep_pkg::FLAG_RST;   // RL8
            en0_q       <= iep_pkg::EN_RST;
            en1_q       <= iep_pkg::EN_RST;
            en4_q       <= iep_pkg::EN_RST;
            prio0_q     <= iep_pkg::PRIO0_RST;  // RL8
            prio1_q     <= iep_pkg::PRIO1_RST;
            stat_q      <= 2'h0;
            mask_q      <= 2'h0;
            irq_q       <= 1'b0;
            prdata_q    <= 32'h0000_0000;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            req_valid_q <= 1'b0;
            req_src_q   <= 3'h0;
            req_level_q <= 3'h0;
        end else if (pclk_en) begin
            flag4_q     <= flag4_d;
            en0_q       <= en0_d;
            en1_q       <= en1_d;
            en4_q       <= en4_d;
            prio0_q     <= prio0_d;
            prio1_q     <= prio1_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            irq_q       <= irq_d;
            prdata_q    <= prdata_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            req_valid_q <= req_valid_d;
            req_src_q   <= req_src_d;
            req_level_q <= req_level_d;
        end
    end

    // ========================================
    // Outputs
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign req_valid     = req_valid_q;
    assign req_src       = req_src_q;
    assign req_level     = req_level_q;
    assign irq           = irq_q;
    assign enable_0_bits = en0_q;
    assign enable_1_bits = en1_q;

    // ========================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Transfer phases
    sequence s_setup;
        pclk_en && psel && !penable;
    endsequence
    sequence s_access;
        pclk_en && psel && penable;
    endsequence

    AST_FLAG_SET: assert property (pclk_en && serial_error_req |=> flag4_q[1])  // RL1
        else $error("Serial error request did not set the flag");
    AST_RSVD_ZERO: assert property (((flag4_q & ~iep_pkg::FLAG4_MASK) == 16'h0000) &&  // RL2
        ((en0_q & ~iep_pkg::EN0_MASK) == 16'h0000) && ((en1_q & ~iep_pkg::EN1_MASK) == 16'h0000))
        else $error("Unimplemented bit set");
    AST_BLOCKED: assert property (pclk_en && (pend == 8'h00) |=> !req_valid_q)  // RL3
        else $error("Request passed with no enabled pending source");
    AST_EN4_ONLY: assert property (pclk_en && psel && penable && pwrite && pready_q &&  // RL6
        (paddr == iep_pkg::OFF_EN4) |=> en4_q == ($past(pwdata[15:0]) & iep_pkg::EN4_MASK))
        else $error("Enable register 4 kept more than bit 1");
    AST_ZERO_PRIO: assert property (req_valid_q |-> req_level_q != 3'h0)  // RL7
        else $error("Request with priority code zero");
    AST_RESET_PRIO: assert property ($rose(presetn) |-> prio0_q == 16'h4444 && flag4_q == 16'h0000)  // RL8
        else $error("Wrong value after reset");
    AST_PRIO0_WRITE: assert property (s_setup ##1 (s_access ##0 (pwrite && paddr == iep_pkg::OFF_PRIO0))  // RL9
        |=> prio0_q == ($past(pwdata[15:0]) & 16'h7777))
        else $error("Priority register 0 write mismatch");
    AST_PRIO1_LOW: assert property (prio1_q[3:0] == 4'h0 && !prio1_q[15] && !prio1_q[11] && !prio1_q[7])  // RL10
        else $error("Priority register 1 reserved bits set");
    AST_CPU_GATE: assert property ($past(pclk_en) && req_valid_q |->  // RL12
        {1'b0, req_level_q} > $past(cpu_level))
        else $error("Request not above processor level");
    AST_PICK: assert property (pclk_en && pick_found && cpu_level == 4'h0 |=>  // RL11
        req_valid_q && req_level_q == $past(pick_level))
        else $error("Highest pending source not presented");
    AST_APB_READY: assert property (s_setup ##1 s_access |-> pready_q)
        else $error("No answer in first access cycle");

endmodule // iep_bank

/* File: include/iep_pkg.sv */
// Constants for the interrupt enable and priority bank
package iep_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [11:0] OFF_FLAG4    = 12'h000;  // Flag register 4
    localparam logic [11:0] OFF_EN0      = 12'h004;  // Enable register 0
    localparam logic [11:0] OFF_EN1      = 12'h008;  // Enable register 1
    localparam logic [11:0] OFF_EN4      = 12'h00c;  // Enable register 4
    localparam logic [11:0] OFF_PRIO0    = 12'h010;  // Priority register 0
    localparam logic [11:0] OFF_PRIO1    = 12'h014;  // Priority register 1
    localparam logic [11:0] OFF_IRQ_STAT = 12'h018;  // Sticky event status
    localparam logic [11:0] OFF_IRQ_MASK = 12'h01c;  // Event mask
    localparam logic [11:0] OFF_REQ_STAT = 12'h020;  // Current request view

    // ========================================
    // Implemented bit masks
    localparam logic [15:0] FLAG4_MASK = 16'h0002;
    localparam logic [15:0] EN0_MASK   = 16'h3fef;
    localparam logic [15:0] EN1_MASK   = 16'h20db;
    localparam logic [15:0] EN4_MASK   = 16'h0002;
    localparam logic [15:0] PRIO0_MASK = 16'h7777;
    localparam logic [15:0] PRIO1_MASK = 16'h7770;

    // ========================================
    // Reset values
    localparam logic [15:0] FLAG_RST   = 16'h0000;
    localparam logic [15:0] EN_RST     = 16'h0000;
    localparam logic [15:0] PRIO0_RST  = 16'h4444;
    localparam logic [15:0] PRIO1_RST  = 16'h4440;

    // ========================================
    // Field positions
    localparam int SERR_BIT   = 1;   // Serial error flag and enable
    localparam int EXT0_BIT   = 0;   // Enable register 0 bits
    localparam int CAP1_BIT   = 1;
    localparam int CMP1_BIT   = 2;
    localparam int TMR1_BIT   = 3;
    localparam int CAP2_BIT   = 5;
    localparam int CMP2_BIT   = 6;
    localparam int TMR2_BIT   = 7;
    localparam logic [3:0] TMR_PRIO_LSB = 4'hc;  // Timer field, both regs
    localparam logic [3:0] CMP_PRIO_LSB = 4'h8;  // Compare field
    localparam logic [3:0] CAP_PRIO_LSB = 4'h4;  // Capture field
    localparam logic [3:0] EXT_PRIO_LSB = 4'h0;  // External 0 field

    // ========================================
    // Arbitration and event status
    localparam int NSRC = 8;                           // Arbitrated sources
    localparam logic [2:0] SERR_LEVEL = 3'h4;          // Serial error level
    localparam int IRQ_SERR = 0;                       // Serial error event
    localparam int IRQ_REQ  = 1;                       // Request raised event
    localparam logic [1:0] IRQ_MASK_W = 2'h3;          // Implemented bits

endpackage

/* File: verilog/iep_prio_pick.sv */
// Highest level pending source selector
`timescale 1ns/100ps
module iep_prio_pick (
    // Pending sources and their levels
    input  wire logic [7:0]  pend,
    input  wire logic [23:0] lvls,
    // Winner
    output logic             found,
    output logic [2:0]       idx,
    output logic [2:0]       level
);

    // ========================================
    // Linear scan; strict compare keeps lowest index on ties
    always_comb begin
        found = 1'b0;
        idx   = 3'h0;
        level = 3'h0;
        for (int i = 0; i < 8; i++) begin
            // Pending sources always carry a nonzero level
            if (pend[i] && (lvls[3*i +: 3] > level)) begin
                found = 1'b1;
                idx   = 3'(i);
                level = lvls[3*i +: 3];
            end
        end
    end

endmodule // iep_prio_pick

/* File: dv/iep_src_model.sv */
// Model of the processor level and the peripheral request sources
`timescale 1ns/100ps
module iep_src_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Commands from the bench
    input  wire logic [6:0] cmd_flags,
    input  wire logic       cmd_serr,
    input  wire logic [3:0] cmd_level,
    // Lines into the bank
    output logic      [6:0] periph_flags,
    output logic            serial_error_req,
    output logic      [2:0] cpu_level_bits,
    output logic            cpu_level_top_bit
);
    logic serr_seen_q;  // Last serial command, for edge detection

    // ========================================
    // Sources hold flags as levels; the serial port pulses once per event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_flags                        <= 7'h00;
            serial_error_req                    <= 1'b0;
            serr_seen_q                         <= 1'b0;
            {cpu_level_top_bit, cpu_level_bits} <= 4'h0;
        end else begin
            periph_flags                        <= cmd_flags;
            // One cycle only, so a stuck level cannot hide a missed clear
            serial_error_req                    <= cmd_serr & ~serr_seen_q;
            serr_seen_q                         <= cmd_serr;
            {cpu_level_top_bit, cpu_level_bits} <= cmd_level;
        end
    end
endmodule // iep_src_model

/* File: dv/iep_bank_tb_top.sv */
// Self-checking bench for the interrupt enable and priority bank
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("ERROR time=%0t got=%h exp=%h", $time, (got), (exp)); end end
module iep_bank_tb_top;
    // Clock, reset and bus
    logic        pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    // Sources, processor level and request outputs
    logic [6:0]  periph_flags, cmd_flags;
    logic        serial_error_req, cpu_level_top_bit, cmd_serr, req_valid, irq;
    logic [2:0]  cpu_level_bits, req_src, req_level;
    logic [3:0]  cmd_level;
    logic [15:0] en0_bits, en1_bits;
    // Bookkeeping
    int          bad_count, check_count, cycle_count;
    // Register map: flag4, en0, en1, en4, prio0, prio1
    localparam logic [11:0] ADDRS  [6] = '{iep_pkg::OFF_FLAG4, iep_pkg::OFF_EN0, iep_pkg::OFF_EN1,
                                           iep_pkg::OFF_EN4, iep_pkg::OFF_PRIO0, iep_pkg::OFF_PRIO1};
    localparam logic [31:0] RST_V  [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h4444, 32'h4440};
    localparam logic [31:0] IMPL_V [6] = '{32'h2, 32'h3fef, 32'h20db, 32'h2, 32'h7777, 32'h7770};

    iep_bank u_iep_bank (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_flags(periph_flags),
        .serial_error_req(serial_error_req), .cpu_level_bits(cpu_level_bits),
        .cpu_level_top_bit(cpu_level_top_bit), .req_valid(req_valid), .req_src(req_src),
        .req_level(req_level), .irq(irq), .enable_0_bits(en0_bits), .enable_1_bits(en1_bits));
    iep_src_model u_iep_src_model (.pclk(pclk), .presetn(presetn), .cmd_flags(cmd_flags),
        .cmd_serr(cmd_serr), .cmd_level(cmd_level), .periph_flags(periph_flags),
        .serial_error_req(serial_error_req), .cpu_level_bits(cpu_level_bits),
        .cpu_level_top_bit(cpu_level_top_bit));

    // ========================================
    // One APB transfer; request held until pready is seen high
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                            output logic [31:0] rd_d, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample pready at each rising edge; write and read data land there
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) bad_count++;
        rd_d = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] r;
        logic        e;
        apb_xfer(1'b1, a, wd, r, e);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb_xfer(1'b0, a, 32'h0, r, e);
    endtask
    // Lets source and request registers catch up, then samples mid-cycle
    task automatic settle();
        repeat (4) @(posedge pclk);
        @(negedge pclk);
    endtask

    // ========================================
    // Reset values of the six flag, enable and priority registers and of req_valid, irq and both enable outputs
    task automatic test_reset();
        logic [31:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(ADDRS[i], d);
            `CHK(d, RST_V[i])
        end
        `CHK({req_valid, irq, en0_bits, en1_bits}, 34'h0)
    endtask

    // Unimplemented bits, bit maps and an unmapped address
    task automatic test_fields();
        logic [31:0] d;
        logic        e;
        for (int i = 0; i < 6; i++) begin
            wr(ADDRS[i], 32'hffff_ffff);
            rd(ADDRS[i], d);
            `CHK(d, IMPL_V[i])
        end
        `CHK(en0_bits, 16'h3fef)
        `CHK(en1_bits, 16'h20db)
        for (int i = 0; i < 6; i++) begin
            wr(ADDRS[i], 32'h0);
            rd(ADDRS[i], d);
            `CHK(d, 32'h0)
        end
        apb_xfer(1'b0, 12'h100, 32'h0, d, e);
        `CHK({e, d}, 33'h1_0000_0000)
    endtask

    // Arbitration by flag, enable, level and processor level
    task automatic test_arb();
        logic [31:0] d;
        wr(iep_pkg::OFF_EN0, 32'h0000_000a);
        wr(iep_pkg::OFF_PRIO0, 32'h0000_2050);
        cmd_flags <= 7'h0a;
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h4d)
        rd(iep_pkg::OFF_REQ_STAT, d);
        `CHK(d, 32'h53)
        wr(iep_pkg::OFF_EN0, 32'h0000_0008);
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h5a)
        wr(iep_pkg::OFF_PRIO0, 32'h0000_0050);
        settle();
        `CHK(req_valid, 1'b0)
        wr(iep_pkg::OFF_EN0, 32'h0000_000b);
        wr(iep_pkg::OFF_PRIO0, 32'h0000_3033);
        cmd_flags <= 7'h0b;
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h43)
        @(posedge pclk);
        cmd_level <= 4'h3;
        settle();
        `CHK(req_valid, 1'b0)
        @(posedge pclk);
        cmd_level <= 4'h8;
        wr(iep_pkg::OFF_PRIO0, 32'h0000_7000);
        settle();
        `CHK(req_valid, 1'b0)
        @(posedge pclk);
        cmd_level <= 4'h0;
        wr(iep_pkg::OFF_EN0, 32'h0000_00e0);
        wr(iep_pkg::OFF_PRIO1, 32'h0000_1650);
        cmd_flags <= 7'h70;
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h6e)
        // Clock enable low freezes the request while the sources move
        @(posedge pclk);
        pclk_en   <= 1'b0;
        cmd_flags <= 7'h50;
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h6e)
        @(posedge pclk);
        pclk_en <= 1'b1;
        settle();
        `CHK({req_valid, req_src, req_level}, 7'h65)
        wr(iep_pkg::OFF_EN0, 32'h0);
        cmd_flags <= 7'h00;
    endtask

    // Serial error flag, its enable, sticky status, mask and interrupt line
    task automatic test_serial();
        logic [31:0] d;
        wr(iep_pkg::OFF_IRQ_STAT, 32'h3);
        wr(iep_pkg::OFF_EN4, 32'h2);
        wr(iep_pkg::OFF_IRQ_MASK, 32'h1);
        cmd_serr <= 1'b1;
        settle();
        `CHK({req_valid, req_src, req_level, irq}, 8'hf9)
        rd(iep_pkg::OFF_FLAG4, d);
        `CHK(d, 32'h2)
        cmd_serr <= 1'b0;
        rd(iep_pkg::OFF_IRQ_STAT, d);
        `CHK(d, 32'h3)
        wr(iep_pkg::OFF_IRQ_STAT, 32'h1);
        settle();
        `CHK(irq, 1'b0)
        wr(iep_pkg::OFF_FLAG4, 32'h0);
        wr(iep_pkg::OFF_EN4, 32'h0);
        cmd_serr <= 1'b1;
        settle();
        `CHK(req_valid, 1'b0)
        rd(iep_pkg::OFF_FLAG4, d);
        `CHK(d, 32'h2)
        cmd_serr <= 1'b0;
    endtask

    // ========================================
    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Free-running 250 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, cmd_serr} = 5'h0;
        pclk_en   = 1'b1;
        paddr     = 12'h000;
        pwdata    = 32'h0;
        cmd_flags = 7'h00;
        cmd_level = 4'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_fields();
        test_arb();
        test_serial();
        // Mid-run reset must bring the flag, enable and priority registers back to their reset values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        print_verdict();
    end
endmodule // iep_bank_tb_top
